// ==== rtl/eeprom_consts.svh ====
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH

// Select byte type codes in the upper nibble.
`define TYPE_MEM 4'ha
`define TYPE_PROT 4'h6

// Bit slot counts: eight data rises, then the acknowledge slot.
`define ACK_SLOT 4'h8
// Slot count seen at a stop that directly follows an acknowledge.
`define STOP_SLOT 4'h1

// Address bit that is low for the protectable lower half.
`define PROT_HALF_BIT 7

// Content of a never written location and the answer of a register read.
`define ERASED_BYTE 8'hff
`define PROT_READ_BYTE 8'h00

// Page buffer holds one sixteen byte page.
`define PAGE_BYTES 16

// Programming time and system clock period, both in nanoseconds.
`define PROG_TIME_NS 5000000
`define CLK_PERIOD_NS 20

`endif

// ==== rtl/eeprom_pkg.sv ====
package eeprom_pkg;

  // Command sequence states of the serial slave.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEL,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_BUSY
  } state_t;

  // Pin levels and the link side data capture, carried together through the synchroniser.
  typedef struct packed {
    logic scl;
    logic sda;
    logic cap;
    logic wc;
    logic [2:0] strap;
  } pin_sample_t;

endpackage

// ==== rtl/i2c_eeprom_slave_protect.sv ====
`timescale 1ns/1ps
`include "eeprom_consts.svh"
module i2c_eeprom_slave_protect
  import eeprom_pkg::*;
#(
  parameter int unsigned PROG_CYCLES =
    (`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_ce,
  input wire logic scl_link,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic chip_strap_bit0,
  input wire logic chip_strap_bit1,
  input wire logic chip_strap_bit2,
  input wire logic write_inhibit_pin,
  output logic write_busy,
  output logic protect_locked
);

  // Width of the programming cycle counter.
  localparam int unsigned CW = $clog2(PROG_CYCLES + 1);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------

  // Two stage release of the asynchronous reset.
  logic [1:0] rst_pipe_q;
  // Released reset used by all other logic except the page buffer, the array and the lock flag.
  logic rst_n;
  // Reset asserts at once and releases after two clock edges.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_pipe_q <= 2'b00;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe_q[1];

  // ---------------------------------------------------------------
  // Link clock domain
  // ---------------------------------------------------------------

  // Data level taken at each rising edge of the serial clock.
  logic bit_cap_q;

  // The data bit is sampled on the serial clock itself.
  always_ff @(posedge scl_link or negedge rst_n) begin
    if (!rst_n) begin
      bit_cap_q <= 1'b0;
    end else begin
      bit_cap_q <= sda_in;
    end
  end

  // ---------------------------------------------------------------
  // Synchronisers and bus events
  // ---------------------------------------------------------------

  // Raw pin levels, first stage, second stage and previous sample.
  pin_sample_t pin_raw, meta_q, sync_q, prev_q;

  assign pin_raw.scl = scl_link;
  assign pin_raw.sda = sda_in;
  assign pin_raw.cap = bit_cap_q;
  assign pin_raw.wc = write_inhibit_pin;
  assign pin_raw.strap = {chip_strap_bit2, chip_strap_bit1, chip_strap_bit0};

  // Every outside level passes two flip-flops; the third keeps history.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else if (clk_ce) begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Rising clock seen in the system domain, delayed by two cycles.
  logic [1:0] rise_dly_q;
  // Qualified bus events.
  logic scl_rise, scl_fall, start_evt, stop_evt, bit_evt;
  // Received data bit from the link side capture.
  logic din;

  assign scl_rise = sync_q.scl & ~prev_q.scl;
  assign scl_fall = ~sync_q.scl & prev_q.scl;
  // A start is data falling while the clock stays high.
  assign start_evt = sync_q.scl & prev_q.scl & prev_q.sda & ~sync_q.sda;
  // A stop is data rising while the clock stays high.
  assign stop_evt = sync_q.scl & prev_q.scl & ~prev_q.sda & sync_q.sda;
  assign bit_evt = rise_dly_q[1];
  assign din = sync_q.cap;

  // The delay lets the captured bit settle through its own synchroniser.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rise_dly_q <= 2'b00;
    end else if (clk_ce) begin
      rise_dly_q <= {rise_dly_q[0], scl_rise};
    end
  end

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------

  // Command state and slot counter.
  state_t state_q;
  logic [3:0] bit_q;
  // Incoming byte shift register and outgoing byte.
  logic [7:0] shreg_q, tx_q;
  // Byte address counter.
  logic [7:0] addr_q;
  // Current command addresses the protection register.
  logic sel_prot_q;
  // Drive request for the data line.
  logic sda_oe_q;
  // Page bytes waiting for programming and their valid marks.
  logic [7:0] page_buf [`PAGE_BYTES];
  logic [`PAGE_BYTES-1:0] mask_q;
  // Protection register write waiting for programming.
  logic pend_q;
  // Programming cycle counter.
  logic [CW-1:0] prog_cnt_q;
  // Nonvolatile array and lock flag; neither is touched by reset.
  // They start in the delivery state: erased array, lock open.
  logic [7:0] mem [256] = '{default: `ERASED_BYTE};
  logic prot_q = 1'b0;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------

  // Type nibble of the received select byte.
  logic [3:0] sel_type;
  // Select byte is for this device and still answered.
  logic sel_match;
  // The current data byte may be written.
  logic wr_allowed;
  // Falling clock that opens the acknowledge slot.
  logic ack_fall;
  // Accepted write data byte.
  logic take_byte;
  // Stop that launches programming.
  logic prog_go;
  // Last cycle of programming.
  logic busy_done;
  // Page entry handled in the current programming cycle.
  logic [3:0] prog_idx;

  assign sel_type = shreg_q[7:4];
  // Chip bits must match straps; a locked register no longer answers.
  assign sel_match = (shreg_q[3:1] == sync_q.strap) &&
    ((sel_type == `TYPE_MEM) || ((sel_type == `TYPE_PROT) && !prot_q));
  // Inhibit high refuses everything; the lock guards only the lower half.
  assign wr_allowed = !sync_q.wc &&
    (sel_prot_q || !(prot_q && !addr_q[`PROT_HALF_BIT]));
  assign ack_fall = scl_fall && (bit_q == `ACK_SLOT);
  assign take_byte = ack_fall && (state_q == ST_WDATA) && wr_allowed;
  // Only a stop one rise after an acknowledge, with work pending, programs.
  assign prog_go = stop_evt && (state_q == ST_WDATA) &&
    (bit_q == `STOP_SLOT) && ((|mask_q) || pend_q);
  assign busy_done = (state_q == ST_BUSY) && (prog_cnt_q == CW'(PROG_CYCLES - 1));
  assign prog_idx = prog_cnt_q[3:0];

  // ---------------------------------------------------------------
  // Command sequencer
  // ---------------------------------------------------------------

  // Bus events drive the state, the slot counter and the data line.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      shreg_q <= 8'h00;
      tx_q <= 8'h00;
      addr_q <= 8'h00;
      sel_prot_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (clk_ce) begin
      if (state_q == ST_BUSY) begin
        // Both lines are ignored until programming ends.
        sda_oe_q <= 1'b0;
        if (busy_done) begin
          state_q <= ST_IDLE;
        end
      end else if (start_evt) begin
        // Start or restart opens a new select byte.
        state_q <= ST_SEL;
        bit_q <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (stop_evt) begin
        // Stop ends the command and may launch programming.
        bit_q <= 4'h0;
        sda_oe_q <= 1'b0;
        state_q <= prog_go ? ST_BUSY : ST_IDLE;
      end else if (state_q != ST_IDLE) begin
        if (bit_evt) begin
          if (bit_q == `ACK_SLOT) begin
            bit_q <= 4'h0;
            // In a read, the master's answer is sampled when we are not driving.
            if ((state_q == ST_RDATA) && !sda_oe_q) begin
              if (din) begin
                state_q <= ST_IDLE;
              end else begin
                tx_q <= mem[addr_q];
                addr_q <= addr_q + 8'h01;
              end
            end
          end else begin
            // Serial data enters most significant bit first.
            shreg_q <= {shreg_q[6:0], din};
            bit_q <= bit_q + 4'h1;
          end
        end else if (scl_fall) begin
          if (bit_q == `ACK_SLOT) begin
            case (state_q)
              ST_SEL: begin
                if (sel_match) begin
                  sda_oe_q <= 1'b1;
                  sel_prot_q <= (sel_type == `TYPE_PROT);
                  if (shreg_q[0]) begin
                    // Read: the first byte comes from the counter, or is the fixed answer for the register.
                    state_q <= ST_RDATA;
                    if (sel_type == `TYPE_PROT) begin
                      tx_q <= `PROT_READ_BYTE;
                    end else begin
                      tx_q <= mem[addr_q];
                      addr_q <= addr_q + 8'h01;
                    end
                  end else begin
                    state_q <= ST_ADDR;
                  end
                end else begin
                  // Not ours: release and wait for the next start.
                  state_q <= ST_IDLE;
                  sda_oe_q <= 1'b0;
                end
              end
              ST_ADDR: begin
                // Address is loaded unless the register is addressed.
                sda_oe_q <= 1'b1;
                if (!sel_prot_q) begin
                  addr_q <= shreg_q;
                end
                state_q <= ST_WDATA;
              end
              ST_WDATA: begin
                // Acknowledge only bytes that may be written.
                sda_oe_q <= wr_allowed;
                // The counter wraps inside the page.
                addr_q[3:0] <= addr_q[3:0] + 4'h1;
              end
              default: begin
                // The master owns the acknowledge slot of a read byte.
                sda_oe_q <= 1'b0;
              end
            endcase
          end else begin
            // Between acknowledges only read data is driven.
            sda_oe_q <= (state_q == ST_RDATA) && !tx_q[~bit_q[2:0]];
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Page buffer and pending work
  // ---------------------------------------------------------------

  // Accepted bytes land at the low address bits; rolled bytes overwrite.
  always_ff @(posedge clk_sys) begin
    if (clk_ce && take_byte && !sel_prot_q) begin
      page_buf[addr_q[3:0]] <= shreg_q;
    end
  end

  // Marks are dropped by programming or by a command that ends without it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= '0;
      pend_q <= 1'b0;
    end else if (clk_ce) begin
      if (busy_done) begin
        mask_q <= '0;
        pend_q <= 1'b0;
      end else if ((state_q != ST_BUSY) && (start_evt || (stop_evt && !prog_go))) begin
        mask_q <= '0;
        pend_q <= 1'b0;
      end else if (take_byte) begin
        if (sel_prot_q) begin
          pend_q <= 1'b1;
        end else begin
          mask_q[addr_q[3:0]] <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Programming cycle
  // ---------------------------------------------------------------

  // Counter runs from the launching stop to the end of the busy time.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prog_cnt_q <= '0;
    end else if (clk_ce) begin
      if (prog_go && (state_q != ST_BUSY)) begin
        prog_cnt_q <= '0;
      end else if (state_q == ST_BUSY) begin
        prog_cnt_q <= prog_cnt_q + CW'(1);
      end
    end
  end

  // One page entry is committed per cycle in the first sixteen cycles.
  always_ff @(posedge clk_sys) begin
    if (clk_ce && (state_q == ST_BUSY) && (prog_cnt_q < CW'(`PAGE_BYTES))) begin
      if (mask_q[prog_idx]) begin
        mem[{addr_q[7:4], prog_idx}] <= page_buf[prog_idx];
      end
    end
  end

  // The lock is set once and has no way back, not even by reset.
  always_ff @(posedge clk_sys) begin
    if (clk_ce && busy_done && pend_q) begin
      prot_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  // Open drain: the line is only ever pulled low.
  logic sda_low_q;
  // Registered status.
  logic busy_q, locked_q;

  // Status flags follow the internal state one cycle later.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sda_low_q <= 1'b0;
      busy_q <= 1'b0;
      locked_q <= 1'b0;
    end else if (clk_ce) begin
      sda_low_q <= 1'b0;
      busy_q <= (state_q == ST_BUSY);
      locked_q <= prot_q;
    end
  end

  assign sda_out = sda_low_q;
  assign sda_oe = sda_oe_q;
  assign write_busy = busy_q;
  assign protect_locked = locked_q;
endmodule // i2c_eeprom_slave_protect

// ==== verif/i2c_eeprom_checker.sv ====
`timescale 1ns/1ps
// ----------------------------------------------
// Port checker of the serial memory slave.
// ----------------------------------------------
module i2c_eeprom_checker #(
  parameter int unsigned PROG_CYCLES = 32
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_ce,
  input wire logic scl_link,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic chip_strap_bit0,
  input wire logic chip_strap_bit1,
  input wire logic chip_strap_bit2,
  input wire logic write_inhibit_pin,
  input wire logic write_busy,
  input wire logic protect_locked
);
  int unsigned busy_cnt; // Cycles the busy flag has been seen high so far.

  // Measures each programming cycle, since its length is far beyond a repetition.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= write_busy ? busy_cnt + 1 : 0;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_open_drain; !sda_out; endproperty
  a_open_drain: assert property (p_open_drain) else $error("data driven high");
  property p_busy_quiet; write_busy |-> !sda_oe; endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("bus driven while busy");
  property p_oe_scl_low; $changed(sda_oe) |-> !scl_link; endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved, clock high");
  property p_lock_keep; !$fell(protect_locked); endproperty
  a_lock_keep: assert property (p_lock_keep) else $error("lock cleared");
  property p_stop_prog; $rose(write_busy) |-> scl_link && sda_in && $past(scl_link, 8); endproperty
  a_stop_prog: assert property (p_stop_prog) else $error("program without stop");
  property p_inhibit; $rose(write_busy) |-> !$past(write_inhibit_pin, 8); endproperty
  a_inhibit: assert property (p_inhibit) else $error("program while inhibited");
  property p_busy_len;
    $fell(write_busy) |-> busy_cnt >= PROG_CYCLES - 1 && busy_cnt <= PROG_CYCLES + 1;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_busy_max; busy_cnt <= PROG_CYCLES + 1; endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
endmodule // i2c_eeprom_checker

bind i2c_eeprom_slave_protect i2c_eeprom_checker #(.PROG_CYCLES(PROG_CYCLES)) i_chk (
  .clk_sys(clk_sys), .resetn(resetn), .clk_ce(clk_ce), .scl_link(scl_link),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .chip_strap_bit0(chip_strap_bit0),
  .chip_strap_bit1(chip_strap_bit1), .chip_strap_bit2(chip_strap_bit2),
  .write_inhibit_pin(write_inhibit_pin), .write_busy(write_busy),
  .protect_locked(protect_locked));

// ==== verif/i2c_master_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------
// Bus master model on the serial link.
// ----------------------------------------------
module i2c_master_model (
  input wire logic clk_link,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  localparam int HALF = 16; // Link ticks per clock phase, well above the slave minimum.

  // The clock stands high and data is released outside frames.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Waits a number of link clock ticks.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_link);
  endtask

  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    tick(1);
    sda_pull <= 1'b0;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF);
    sda_pull <= 1'b1;
    tick(HALF);
    scl <= 1'b0;
    tick(HALF / 2);
  endtask

  // One bit slot: data moves mid low phase, the line is read late in the high phase.
  task automatic bit_io(input logic b, output logic r);
    sda_pull <= ~b;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF - 2);
    r = sda;
    tick(2);
    scl <= 1'b0;
    tick(HALF / 2);
  endtask

  // Sends a byte and returns the slave's acknowledge.
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Receives a byte and acknowledges it when mack is high.
  task automatic rx(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~mack, r);
  endtask

  // Stop: data rises while the clock is high.
  task automatic stop();
    sda_pull <= 1'b1;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF);
    sda_pull <= 1'b0;
    tick(HALF);
  endtask
endmodule // i2c_master_model

// ==== verif/i2c_eeprom_slave_protect_bench.sv ====
`timescale 1ns/1ps
`include "eeprom_consts.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
// ----------------------------------------------
// Self-checking bench of the serial memory slave.
// ----------------------------------------------
module i2c_eeprom_slave_protect_bench;
  localparam int unsigned PROG = 400; // Short programming cycle for simulation.
  logic clk_sys, clk_link, resetn, clk_ce, inhibit, ack;
  logic [2:0] strap; // Chip strap levels, bit 2 on the top strap.
  logic [7:0] d;
  wire logic scl, sda_pull, sda_oe, sda_out, write_busy, protect_locked;
  wire logic sda = ~(sda_pull | sda_oe); // Pulled-up wire, either party pulls low.
  int n_fail, total_checks;

  // System clock of 20 ns and an unrelated 15 ns link tick.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #3;
    forever #7.5 clk_link = ~clk_link;
  end

  i2c_eeprom_slave_protect #(.PROG_CYCLES(PROG)) i_i2c_eeprom_slave_protect (
    .clk_sys(clk_sys), .resetn(resetn), .clk_ce(clk_ce), .scl_link(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .chip_strap_bit0(strap[0]),
    .chip_strap_bit1(strap[1]), .chip_strap_bit2(strap[2]), .write_inhibit_pin(inhibit),
    .write_busy(write_busy), .protect_locked(protect_locked));
  i2c_master_model i_i2c_master_model (.clk_link(clk_link), .sda(sda), .scl(scl),
    .sda_pull(sda_pull));

  // Prints the counts and the verdict, then ends the run.
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Start plus a select byte for this strap setting.
  task sel(input logic [3:0] t, input logic rw, output logic a);
    i_i2c_master_model.start();
    i_i2c_master_model.tx({t, strap, rw}, a);
  endtask

  // Waits, bounded, until the programming cycle ends.
  task wait_prog;
    for (int i = 0; i < PROG + 50 && write_busy !== 1'b0; i++) cyc(1);
    if (write_busy !== 1'b0) begin
      n_fail++;
      final_report();
    end
  endtask

  // Write command of n bytes counting up from d0; e is the expected data acknowledge.
  task wr(input logic [3:0] t, input logic [7:0] a, d0, input int n, input logic e);
    sel(t, 1'b0, ack);
    `CHK(ack, 1'b1)
    i_i2c_master_model.tx(a, ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < n; i++) begin
      i_i2c_master_model.tx(d0 + 8'(i), ack);
      `CHK(ack, e)
    end
    i_i2c_master_model.stop();
  endtask

  // Random read of one byte.
  task rd(input logic [7:0] a, e);
    sel(`TYPE_MEM, 1'b0, ack);
    i_i2c_master_model.tx(a, ack);
    sel(`TYPE_MEM, 1'b1, ack);
    `CHK(ack, 1'b1)
    i_i2c_master_model.rx(1'b0, d);
    `CHK(d, e)
    i_i2c_master_model.stop();
  endtask

  // Every chip code and one unknown type; only the strapped code answers.
  task s_select;
    for (int i = 0; i < 8; i++) begin
      i_i2c_master_model.start();
      i_i2c_master_model.tx({`TYPE_MEM, 3'(i), 1'b1}, ack);
      `CHK(ack, 3'(i) === strap)
      i_i2c_master_model.rx(1'b0, d);
      i_i2c_master_model.stop();
    end
    sel(4'h5, 1'b1, ack);
    `CHK(ack, 1'b0)
    i_i2c_master_model.stop();
  endtask

  // Aborted write, byte write, polling during the cycle, then both read kinds.
  task s_byte;
    sel(`TYPE_MEM, 1'b0, ack);
    i_i2c_master_model.tx(8'h40, ack);
    i_i2c_master_model.stop();
    cyc(4);
    `CHK(write_busy, 1'b0)
    wr(`TYPE_MEM, 8'h85, 8'h3c, 1, 1'b1);
    cyc(2);
    `CHK(write_busy, 1'b1)
    sel(`TYPE_MEM, 1'b0, ack);
    `CHK(ack, 1'b0)
    i_i2c_master_model.stop();
    wait_prog();
    sel(`TYPE_MEM, 1'b0, ack);
    `CHK(ack, 1'b1)
    i_i2c_master_model.tx(8'h85, ack);
    sel(`TYPE_MEM, 1'b1, ack);
    i_i2c_master_model.rx(1'b0, d);
    `CHK(d, 8'h3c)
    i_i2c_master_model.stop();
    sel(`TYPE_MEM, 1'b1, ack);
    i_i2c_master_model.rx(1'b0, d);
    `CHK(d, `ERASED_BYTE)
    i_i2c_master_model.stop();
  endtask

  // Page write wrapping inside its page, then reads across the array end.
  task s_page;
    wr(`TYPE_MEM, 8'hfe, 8'h11, 3, 1'b1);
    wait_prog();
    rd(8'hf0, 8'h13);
    wr(`TYPE_MEM, 8'h00, 8'h5a, 1, 1'b1);
    wait_prog();
    sel(`TYPE_MEM, 1'b0, ack);
    i_i2c_master_model.tx(8'hfe, ack);
    sel(`TYPE_MEM, 1'b1, ack);
    i_i2c_master_model.rx(1'b1, d);
    `CHK(d, 8'h11)
    i_i2c_master_model.rx(1'b1, d);
    `CHK(d, 8'h12)
    i_i2c_master_model.rx(1'b0, d);
    `CHK(d, 8'h5a)
    i_i2c_master_model.rx(1'b0, d);
    `CHK(d, 8'hff)
    i_i2c_master_model.stop();
  endtask

  // Inhibit held high over whole commands refuses memory and lock writes.
  task s_inhibit;
    inhibit <= 1'b1;
    cyc(4);
    wr(`TYPE_MEM, 8'h90, 8'h77, 1, 1'b0);
    wr(`TYPE_PROT, 8'h00, 8'h00, 1, 1'b0);
    cyc(4);
    `CHK(write_busy, 1'b0)
    `CHK(protect_locked, 1'b0)
    inhibit <= 1'b0;
    cyc(4);
    rd(8'h90, `ERASED_BYTE);
  endtask

  // Setting the lock, its effect, and its survival over a reset pulse.
  task s_protect;
    wr(`TYPE_PROT, 8'h33, 8'h99, 1, 1'b1);
    wait_prog();
    cyc(2);
    `CHK(protect_locked, 1'b1)
    wr(`TYPE_MEM, 8'h7f, 8'h01, 1, 1'b0);
    cyc(4);
    `CHK(write_busy, 1'b0)
    rd(8'h7f, `ERASED_BYTE);
    wr(`TYPE_MEM, 8'h80, 8'h42, 1, 1'b1);
    wait_prog();
    rd(8'h80, 8'h42);
    sel(`TYPE_PROT, 1'b1, ack);
    `CHK(ack, 1'b0)
    i_i2c_master_model.stop();
    resetn <= 1'b0;
    cyc(5);
    resetn <= 1'b1;
    cyc(10);
    `CHK(protect_locked, 1'b1)
    sel(`TYPE_PROT, 1'b0, ack);
    `CHK(ack, 1'b0)
    i_i2c_master_model.stop();
    rd(8'h85, 8'h3c);
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial begin
    clk_ce = 1'b1;
    resetn = 1'b0;
    inhibit = 1'b0;
    strap = 3'b101;
    n_fail = 0;
    total_checks = 0;
    cyc(5);
    resetn <= 1'b1;
    cyc(10);
    s_select();
    s_byte();
    s_page();
    s_inhibit();
    s_protect();
    final_report();
  end
endmodule // i2c_eeprom_slave_protect_bench
